// ==== rtl/lpdsc_pkg.sv ====
// Package for the LPDDR deep-sleep and clock-stop controller.
// Assumes a single 25 MHz controller clock.
package lpdsc_pkg;
    localparam int unsigned CLK_MHZ = 25;
    localparam int unsigned EXIT_NOP_US = 200;
    localparam int unsigned EXIT_NOP_CYC = EXIT_NOP_US * CLK_MHZ;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned QUIET_CYC = 8;
    localparam int unsigned RESTART_NOP_CYC = 1;
    // Command encoding on {cs_n, ras_n, cas_n, we_n}.
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_BST = 4'h6;
    localparam logic [3:0] CMD_DESEL = 4'hf;
    typedef enum logic [2:0] {
        LPDSC_RUN = 3'b000,
        LPDSC_ENTER = 3'b001,
        LPDSC_SLEEP = 3'b011,
        LPDSC_WAKE = 3'b010,
        LPDSC_INIT = 3'b110,
        LPDSC_STOP = 3'b111,
        LPDSC_RESTART = 3'b101
    } lpdsc_state_t;
endpackage

// ==== rtl/lpdsc_cnt_if.sv ====
// Interface joining the controller with its down-counter.
// Assumes both ends share the controller clock.
`timescale 1ns/1ns
interface lpdsc_cnt_if #(parameter int W = 16);
    logic load;
    logic [W-1:0] value;
    logic done;
    modport ctl (output load, output value, input done);
    modport cnt (input load, input value, output done);
endinterface

// ==== rtl/lpdsc_timer.sv ====
// Down-counter that times waits for the controller.
// Assumes a load pulse from the controller.
`timescale 1ns/1ns
module lpdsc_timer #(
    parameter int W = 16
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Control.
    lpdsc_cnt_if.cnt c
);
    logic [W-1:0] count;
    logic [W-1:0] next_count;

    always_comb
    begin
        next_count = count;
        if (c.load)
            next_count = c.value;
        else if (count != '0)
            next_count = count - 1'b1;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            count <= '0;
        else
            count <= next_count;
    end

    assign c.done = (count == '0) && !c.load;
endmodule

// ==== rtl/lpdsc_ctrl.sv ====
// Controller that puts an LPDDR memory into deepest sleep and stops its clock.
// Assumes the user issues commands with a valid/ready handshake and reports bus idle.
`timescale 1ns/1ns
module lpdsc_ctrl
    import lpdsc_pkg::*;
#(
    parameter int unsigned EXIT_CYC = lpdsc_pkg::EXIT_NOP_CYC,
    parameter int unsigned QUIET = lpdsc_pkg::QUIET_CYC
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // User command port.
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_code,
    output logic cmd_ready,
    // User power requests and status.
    input wire logic sleep_req,
    input wire logic wake_req,
    input wire logic stop_req,
    input wire logic banks_idle,
    input wire logic bus_busy,
    input wire logic init_done,
    output logic deep_sleep,
    output logic need_init,
    output logic clk_stopped,
    // Memory pins.
    output logic ck_en,
    output logic cke,
    output logic [3:0] mem_cmd
);
    import lpdsc_pkg::*;

    lpdsc_cnt_if #(.W(CNT_W)) tif ();
    lpdsc_timer #(.W(CNT_W)) u_timer (.mclk(mclk), .rst_n(rst_n), .c(tif));

    lpdsc_state_t state, next_state;
    logic next_cke, next_ck_en, next_flag, next_need;
    logic [3:0] next_cmd;
    logic load;
    logic [CNT_W-1:0] value;
    logic quiet;
    logic [CNT_W-1:0] quiet_cnt, next_quiet_cnt;
    logic flag;

    assign tif.load = load;
    assign tif.value = value;
    assign deep_sleep = flag;
    assign clk_stopped = (state == LPDSC_STOP);
    assign quiet = (quiet_cnt == '0) && !bus_busy;
    // Access commands pass only in run state and never while the flag stands.
    assign cmd_ready = (state == LPDSC_RUN) && !flag && !sleep_req && !stop_req;

    always_comb
    begin
        next_state = state;
        next_cke = cke;
        next_ck_en = ck_en;
        next_flag = flag;
        next_need = need_init;
        next_cmd = CMD_NOP;
        load = 1'b0;
        value = '0;
        next_quiet_cnt = (quiet_cnt != '0) ? quiet_cnt - 1'b1 : quiet_cnt;
        unique case (state)
            LPDSC_RUN:
            begin
                if (cmd_valid && cmd_ready)
                begin
                    next_cmd = cmd_code;
                    next_quiet_cnt = CNT_W'(QUIET);
                end
                else if (sleep_req && banks_idle && quiet)
                begin
                    next_cmd = CMD_BST;
                    next_cke = 1'b0;
                    next_state = LPDSC_ENTER;
                end
                else if (stop_req && quiet && !flag)
                begin
                    next_ck_en = 1'b0;
                    next_state = LPDSC_STOP;
                end
                else if (flag && init_done)
                begin
                    next_flag = 1'b0;
                    next_need = 1'b0;
                end
            end
            LPDSC_ENTER:
            begin
                next_flag = 1'b1;
                next_cmd = CMD_NOP;
                next_state = LPDSC_SLEEP;
            end
            LPDSC_SLEEP:
            begin
                next_cke = 1'b0;
                if (wake_req)
                begin
                    next_cke = 1'b1;
                    load = 1'b1;
                    value = CNT_W'(EXIT_CYC);
                    next_state = LPDSC_WAKE;
                end
            end
            LPDSC_WAKE:
            begin
                next_cmd = CMD_NOP;
                if (tif.done)
                begin
                    next_need = 1'b1;
                    next_state = LPDSC_RUN;
                end
            end
            LPDSC_STOP:
            begin
                next_ck_en = 1'b0;
                if (!stop_req)
                begin
                    next_ck_en = 1'b1;
                    load = 1'b1;
                    value = CNT_W'(RESTART_NOP_CYC);
                    next_state = LPDSC_RESTART;
                end
            end
            LPDSC_RESTART:
            begin
                next_cmd = CMD_NOP;
                if (tif.done)
                    next_state = LPDSC_RUN;
            end
            default:
                next_state = LPDSC_RUN;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state <= LPDSC_RUN;
            cke <= 1'b1;
            ck_en <= 1'b1;
            flag <= 1'b0;
            need_init <= 1'b0;
            mem_cmd <= CMD_NOP;
            quiet_cnt <= '0;
        end
        else
        begin
            state <= next_state;
            cke <= next_cke;
            ck_en <= next_ck_en;
            flag <= next_flag;
            need_init <= next_need;
            mem_cmd <= next_cmd;
            quiet_cnt <= next_quiet_cnt;
        end
    end

    property p_dpd_entry;
        @(posedge mclk) disable iff (!rst_n)
        (state == LPDSC_RUN && next_state == LPDSC_ENTER) |=> (mem_cmd == CMD_BST && !cke);
    endproperty
    a_dpd_entry: assert property (p_dpd_entry) else $error("bad sleep entry");

    property p_entry_idle;
        @(posedge mclk) disable iff (!rst_n)
        (state == LPDSC_RUN && next_state == LPDSC_ENTER) |-> (banks_idle && !bus_busy);
    endproperty
    a_entry_idle: assert property (p_entry_idle) else $error("sleep entry while busy");

    property p_cke_low;
        @(posedge mclk) disable iff (!rst_n)
        (state == LPDSC_SLEEP) |-> !cke;
    endproperty
    a_cke_low: assert property (p_cke_low) else $error("cke high in sleep");

    property p_wake_nop;
        @(posedge mclk) disable iff (!rst_n)
        (state == LPDSC_WAKE) |-> (cke && mem_cmd == CMD_NOP);
    endproperty
    a_wake_nop: assert property (p_wake_nop) else $error("non-NOP during wake");

    property p_flag_block;
        @(posedge mclk) disable iff (!rst_n)
        flag |-> !cmd_ready;
    endproperty
    a_flag_block: assert property (p_flag_block) else $error("command passed in sleep");

    property p_stop_pins;
        @(posedge mclk) disable iff (!rst_n)
        (state == LPDSC_STOP) |-> (!ck_en && cke);
    endproperty
    a_stop_pins: assert property (p_stop_pins) else $error("bad clock stop pins");

    property p_stop_quiet;
        @(posedge mclk) disable iff (!rst_n)
        (state == LPDSC_RUN && next_state == LPDSC_STOP) |-> (quiet_cnt == '0);
    endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("stop before delays");

    property p_restart_nop;
        @(posedge mclk) disable iff (!rst_n)
        $fell(clk_stopped) |-> (ck_en && mem_cmd == CMD_NOP);
    endproperty
    a_restart_nop: assert property (p_restart_nop) else $error("no NOP at restart");

    c_sleep: cover property (@(posedge mclk) state == LPDSC_SLEEP);
    c_wake: cover property (@(posedge mclk) state == LPDSC_WAKE && tif.done);
    c_stop: cover property (@(posedge mclk) $fell(clk_stopped));
endmodule

// ==== verif/lpdsc_dev_model.sv ====
// Behavioural memory device driven by the controller's command and clock pins.
// Assumes commands are sampled on mclk edges while the clock is running.
`timescale 1ns/1ns
module lpdsc_dev_model
    import lpdsc_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Controller pins.
    input wire logic ck_en,
    input wire logic cke,
    input wire logic [3:0] mem_cmd,
    input wire logic init_done,
    // Device status.
    output logic in_sleep,
    output logic mode_lost,
    output logic restart_bad
);
    logic ran;
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            in_sleep <= 1'b0;
            mode_lost <= 1'b0;
            restart_bad <= 1'b0;
            ran <= 1'b1;
        end
        else if (ck_en)
        begin
            ran <= 1'b1;
            if (!cke && mem_cmd == CMD_BST)
            begin
                in_sleep <= 1'b1;
                mode_lost <= 1'b1;
            end
            else if (cke)
                in_sleep <= 1'b0;
            if (init_done && !in_sleep)
                mode_lost <= 1'b0;
            if (!ran && mem_cmd != CMD_NOP)
                restart_bad <= 1'b1;
        end
        else
            ran <= 1'b0;
    end
endmodule

// ==== verif/lpdsc_ctrl_bench.sv ====
// Self-checking bench for the deep-sleep and clock-stop controller.
// Assumes the device model answers on the memory pins.
`timescale 1ns/1ns
module lpdsc_ctrl_bench;
    import lpdsc_pkg::*;
    localparam int unsigned EXIT_SIM = 20;
    typedef struct packed {logic [3:0] cmd; logic cke;} lpdsc_exp_t;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic cmd_valid = 1'b0;
    logic [3:0] cmd_code = 4'h0;
    logic sleep_req = 1'b0;
    logic wake_req = 1'b0;
    logic stop_req = 1'b0;
    logic banks_idle = 1'b1;
    logic bus_busy = 1'b0;
    logic init_done = 1'b0;
    logic cmd_ready, deep_sleep, need_init, clk_stopped, ck_en, cke, dev_sleep, dev_lost, dev_bad;
    logic [3:0] mem_cmd;
    lpdsc_exp_t exp_q[$];
    int err_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int n;
    int seed = 32'hd2ba8c8f;
    logic [31:0] r;
    always #20 mclk = ~mclk;
    lpdsc_ctrl #(.EXIT_CYC(EXIT_SIM), .QUIET(QUIET_CYC)) lpdsc_ctrl_inst (.mclk(mclk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_ready(cmd_ready), .sleep_req(sleep_req),
        .wake_req(wake_req), .stop_req(stop_req), .banks_idle(banks_idle), .bus_busy(bus_busy),
        .init_done(init_done), .deep_sleep(deep_sleep), .need_init(need_init), .clk_stopped(clk_stopped),
        .ck_en(ck_en), .cke(cke), .mem_cmd(mem_cmd));
    lpdsc_dev_model lpdsc_dev_model_inst (.mclk(mclk), .rst_n(rst_n), .ck_en(ck_en), .cke(cke),
        .mem_cmd(mem_cmd), .init_done(init_done), .in_sleep(dev_sleep), .mode_lost(dev_lost),
        .restart_bad(dev_bad));
    task automatic check(input logic got, input logic want, input string msg);
        num_checks++;
        if (got !== want)
        begin
            err_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic cmp_cmd(input lpdsc_exp_t got, input lpdsc_exp_t want);
        check(got === want, 1'b1, "wrong command or clock-enable on the pins");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic issue();
        r = $random(seed);
        exp_q.push_back({4'(r[2:0] % 3'h6), 1'b1});
        @(posedge mclk) cmd_valid <= 1'b1;
        cmd_code <= 4'(r[2:0] % 3'h6);
        do @(negedge mclk); while (cmd_ready !== 1'b1);
        @(posedge mclk) cmd_valid <= 1'b0;
    endtask
    task automatic hold(input int cycles, input logic want_cke);
        repeat (cycles)
        begin
            @(negedge mclk);
            check(cke, want_cke, "clock-enable level wrong");
        end
    endtask
    always @(negedge mclk)
        if (rst_n && mem_cmd !== CMD_NOP)
        begin
            if (exp_q.size() == 0)
                check(1'b0, 1'b1, "command with no note");
            else
                cmp_cmd({mem_cmd, cke}, exp_q.pop_front());
        end
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_count++;
            final_report();
        end
    end
    initial
    begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (6) issue();
        $display("test commands done");
        @(posedge mclk) bus_busy <= 1'b1;
        sleep_req <= 1'b1;
        hold(12, 1'b1);
        @(posedge mclk) bus_busy <= 1'b0;
        banks_idle <= 1'b0;
        hold(6, 1'b1);
        exp_q.push_back({CMD_BST, 1'b0});
        @(posedge mclk) banks_idle <= 1'b1;
        for (n = 0; n < 40 && deep_sleep !== 1'b1; n++) @(negedge mclk);
        check(deep_sleep, 1'b1, "no deep-sleep flag");
        @(posedge mclk) sleep_req <= 1'b0;
        cmd_valid <= 1'b1;
        hold(10, 1'b0);
        check(cmd_ready, 1'b0, "command taken in deep sleep");
        check(dev_lost && dev_sleep, 1'b1, "device not in deepest sleep");
        $display("test sleep done");
        @(posedge mclk) wake_req <= 1'b1;
        cmd_valid <= 1'b0;
        for (n = 0; n < 60 && need_init !== 1'b1; n++) @(negedge mclk);
        check(n >= EXIT_SIM && cke === 1'b1, 1'b1, "exit NOP period too short");
        @(posedge mclk) wake_req <= 1'b0;
        cmd_valid <= 1'b1;
        hold(3, 1'b1);
        check(cmd_ready, 1'b0, "command taken before re-init");
        @(posedge mclk) init_done <= 1'b1;
        cmd_valid <= 1'b0;
        @(posedge mclk) init_done <= 1'b0;
        hold(3, 1'b1);
        check(deep_sleep | need_init | dev_lost, 1'b0, "flags not cleared by re-init");
        $display("test wake done");
        issue();
        @(posedge mclk) stop_req <= 1'b1;
        for (n = 0; n < 40 && ck_en !== 1'b0; n++) @(negedge mclk);
        check(n >= QUIET_CYC && clk_stopped === 1'b1, 1'b1, "clock stopped too early");
        hold(5, 1'b1);
        check(ck_en | dev_sleep, 1'b0, "clock restarted or state lost");
        @(posedge mclk) stop_req <= 1'b0;
        issue();
        hold(QUIET_CYC, 1'b1);
        check(dev_bad | ~ck_en, 1'b0, "no NOP on restart before access");
        check(exp_q.size() == 0, 1'b1, "noted command never reached the pins");
        $display("test clock stop done");
        final_report();
    end
endmodule
